//--- plc_defs.vh
`ifndef PLC_DEFS_VH
`define PLC_DEFS_VH

// ****************************************
// Register indices and own byte addresses
// ****************************************
`define PLC_IDX_SAVE_CTRL 10'h01f
`define PLC_IDX_SAVE_ADDR 10'h020
`define PLC_A_MODE 12'h000
`define PLC_A_CFG 12'h004
`define PLC_A_STOP_TAB 12'h008
`define PLC_A_OUT_IMG 12'h00c
`define PLC_A_IN_IMG 12'h010
`define PLC_A_IMM_IN 12'h014
`define PLC_A_IMM_OUT 12'h018
`define PLC_A_AIN 12'h01c
`define PLC_A_AOUT 12'h024

// ****************************************
// Field positions and values
// ****************************************
`define PLC_SAVE_REQ_BIT 7
`define PLC_SIZE_NONE 2'h0
`define PLC_MODE_RUN_BIT 0
`define PLC_MODE_STOP_BIT 1
`define PLC_CFG_FREEZE_BIT 0
`define PLC_CFG_FILT_BIT 1
`define PLC_CFG_PCT_LSB 8
`define PLC_CFG_PCT_MSB 13
`define PLC_SW_STOP 2'h0
`define PLC_SW_TERM 2'h1
`define PLC_SW_RUN 2'h2
`define PLC_HTRANS_NONSEQ 2'h2
`define PLC_HSIZE_WORD 3'h2

// ****************************************
// Reset values and timing
// ****************************************
`define PLC_PCT_RESET 6'h0a
`define PLC_PCT_STEP 6'h05
`define PLC_PCT_MAX 6'h32
`define PLC_STOP_TAB_RESET 8'h00
`define PLC_COMM_UNIT_CYC 21'h000064
`define PLC_SAVE_MAX_NS 64'h00000000004c4b40
`define PLC_CLK_MHZ 64'h00000000000000fa
`define PLC_NS_PER_US 64'h00000000000003e8
`define PLC_SAVE_MARGIN 21'h000004
`define PLC_WARM_DONE 2'h3
`define PLC_QDEPTH 3'h4

`endif

//--- plc_far_model.sv
`timescale 1ns/1ns
`default_nettype none
// ****************************************
// Program engine and EEPROM stand-in
// ****************************************
module plc_far_model (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic i_slow,
   input wire logic i_exec,
   input wire logic i_ee_req,
   input wire logic [15:0] i_ee_addr,
   output logic o_scan_done,
   output logic o_ee_done,
   output logic [7:0] o_save_cnt,
   output logic [15:0] o_last_addr
);
   logic [7:0] exec_cnt_r;
   logic [7:0] ee_cnt_r;
   // Slow mode never answers, so the device must give up on its own
   always @(posedge i_clock) begin
      if (i_sys_rst || !i_exec) begin
         exec_cnt_r <= 8'h00;
      end else if (exec_cnt_r != 8'hff) begin
         exec_cnt_r <= exec_cnt_r + 8'h01;
      end
      if (i_sys_rst || !i_ee_req) begin
         ee_cnt_r <= 8'h00;
      end else if (ee_cnt_r != 8'hff) begin
         ee_cnt_r <= ee_cnt_r + 8'h01;
      end
      o_scan_done <= !i_sys_rst && exec_cnt_r == 8'h08;
      o_ee_done <= !i_sys_rst && !i_slow && ee_cnt_r == 8'h0c;
      if (i_sys_rst) begin
         o_save_cnt <= 8'h00;
         o_last_addr <= 16'h0000;
      end else if (o_ee_done && i_ee_req) begin
         o_save_cnt <= o_save_cnt + 8'h01;
         o_last_addr <= i_ee_addr;
      end
   end
endmodule // plc_far_model
`default_nettype wire

//--- plc_mode_save.v
`include "plc_defs.vh"
`timescale 1ns/1ns
`default_nettype none

module plc_mode_save #(
   parameter [63:0] SAVE_MAX_CYC =
      (`PLC_SAVE_MAX_NS * `PLC_CLK_MHZ) / `PLC_NS_PER_US
) (
   input wire i_clock,
   input wire i_sys_rst,
   input wire i_hsel,
   input wire [31:0] i_haddr,
   input wire [1:0] i_htrans,
   input wire i_hwrite,
   input wire [2:0] i_hsize,
   input wire [31:0] i_hwdata,
   input wire i_hready,
   output reg [31:0] o_hrdata,
   output reg o_hreadyout,
   output reg o_hresp,
   input wire [1:0] i_mode_sw,
   input wire [7:0] i_din,
   input wire [15:0] i_ain,
   input wire i_scan_done,
   input wire i_stop_instr,
   input wire [7:0] i_int_evt,
   input wire i_isr_done,
   input wire i_ee_done,
   output reg o_run,
   output reg o_download_ok,
   output reg o_exec,
   output reg o_comm_active,
   output reg [7:0] o_dout,
   output reg [15:0] o_aout,
   output reg o_ee_req,
   output reg [15:0] o_ee_addr,
   output reg [1:0] o_ee_size,
   output reg o_isr_valid,
   output reg [2:0] o_isr_id
);

   // ****************************************
   // Local codes
   // ****************************************
   localparam [3:0] R_MODE = 4'h0;
   localparam [3:0] R_CFG = 4'h1;
   localparam [3:0] R_TAB = 4'h2;
   localparam [3:0] R_OIMG = 4'h3;
   localparam [3:0] R_IIMG = 4'h4;
   localparam [3:0] R_IMMI = 4'h5;
   localparam [3:0] R_IMMO = 4'h6;
   localparam [3:0] R_AIN = 4'h7;
   localparam [3:0] R_AOUT = 4'h8;
   localparam [3:0] R_SCTL = 4'h9;
   localparam [3:0] R_SADR = 4'ha;
   localparam [3:0] R_NONE = 4'hf;

   localparam [5:0] S_STOP = 6'h01;
   localparam [5:0] S_IN = 6'h02;
   localparam [5:0] S_EXEC = 6'h04;
   localparam [5:0] S_OUT = 6'h08;
   localparam [5:0] S_SAVE = 6'h10;
   localparam [5:0] S_COMM = 6'h20;

   localparam [20:0] SAVE_LIMIT = SAVE_MAX_CYC[20:0] - `PLC_SAVE_MARGIN;

   // ****************************************
   // Functions
   // ****************************************
   function [3:0] reg_dec;
      input [11:0] a;
      begin
         case (a)
            `PLC_A_MODE: reg_dec = R_MODE;
            `PLC_A_CFG: reg_dec = R_CFG;
            `PLC_A_STOP_TAB: reg_dec = R_TAB;
            `PLC_A_OUT_IMG: reg_dec = R_OIMG;
            `PLC_A_IN_IMG: reg_dec = R_IIMG;
            `PLC_A_IMM_IN: reg_dec = R_IMMI;
            `PLC_A_IMM_OUT: reg_dec = R_IMMO;
            `PLC_A_AIN: reg_dec = R_AIN;
            `PLC_A_AOUT: reg_dec = R_AOUT;
            {`PLC_IDX_SAVE_CTRL, 2'b00}: reg_dec = R_SCTL;
            {`PLC_IDX_SAVE_ADDR, 2'b00}: reg_dec = R_SADR;
            default: reg_dec = R_NONE;
         endcase
      end
   endfunction

   // Lowest waiting event of a group: {found, index}
   function [2:0] first_evt;
      input [3:0] v;
      begin
         if (v[0])
            first_evt = 3'h4;
         else if (v[1])
            first_evt = 3'h5;
         else if (v[2])
            first_evt = 3'h6;
         else if (v[3])
            first_evt = 3'h7;
         else
            first_evt = 3'h0;
      end
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   reg [1:0] sw1_r, sw2_r, sw3_r, sw_r, sw_prev_r;
   reg [7:0] din1_r, din2_r, din3_r, din_r;
   reg [1:0] warm_r;
   reg sw_ok_r;
   wire [7:0] din_agree = ~(din2_r ^ din3_r);

   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         sw1_r <= `PLC_SW_STOP;
         sw2_r <= `PLC_SW_STOP;
         sw3_r <= `PLC_SW_STOP;
         sw_r <= `PLC_SW_STOP;
         sw_prev_r <= `PLC_SW_STOP;
         din1_r <= 8'h00;
         din2_r <= 8'h00;
         din3_r <= 8'h00;
         din_r <= 8'h00;
         warm_r <= 2'h0;
         sw_ok_r <= 1'b0;
      end else begin
         sw1_r <= i_mode_sw;
         sw2_r <= sw1_r;
         sw3_r <= sw2_r;
         din1_r <= i_din;
         din2_r <= din1_r;
         din3_r <= din2_r;
         din_r <= (din_r & ~din_agree) | (din3_r & din_agree);
         sw_prev_r <= sw_r;
         if (warm_r != `PLC_WARM_DONE)
            warm_r <= warm_r + 2'h1;
         // Flops hold reset zeroes until the pipe has refilled
         if (warm_r == `PLC_WARM_DONE && sw2_r == sw3_r) begin
            sw_r <= sw3_r;
            sw_ok_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // Bus slave
   // ****************************************
   reg wr_pend_r;
   reg [3:0] wr_sel_r;
   reg [7:0] save_ctl_r;
   reg [15:0] save_adr_r;
   reg [7:0] stop_tab_r, out_img_r, in_img_r;
   reg [5:0] pct_r;
   reg freeze_r, filt_en_r;
   reg [15:0] ain_filt_r;
   reg [5:0] state_r;
   reg save_clr;
   reg [31:0] rd_val;
   reg [15:0] ee_zero;

   wire addr_ok = i_hsel && i_hready && i_htrans == `PLC_HTRANS_NONSEQ &&
      i_hsize == `PLC_HSIZE_WORD;
   wire [3:0] sel_now = reg_dec(i_haddr[11:0]);
   wire wr_mode = wr_pend_r && wr_sel_r == R_MODE;
   wire rem_ok = sw_r != `PLC_SW_STOP;
   wire rem_run = wr_mode && i_hwdata[`PLC_MODE_RUN_BIT] && rem_ok;
   wire rem_stop = wr_mode && i_hwdata[`PLC_MODE_STOP_BIT] && rem_ok;
   wire [5:0] pct_wr = i_hwdata[`PLC_CFG_PCT_MSB:`PLC_CFG_PCT_LSB];
   wire pct_ok = pct_wr <= `PLC_PCT_MAX &&
      (pct_wr % `PLC_PCT_STEP) == 6'h00;
   wire [16:0] filt_sum = {1'b0, ain_filt_r} + {1'b0, i_ain};
   wire [15:0] ain_val = filt_en_r ? ain_filt_r : i_ain;

   always @* begin
      ee_zero = 16'h0000;
      case (sel_now)
         R_MODE: rd_val = {29'h0, sw_r, o_run};
         R_CFG: rd_val = {18'h0, pct_r, 6'h00, filt_en_r, freeze_r};
         R_TAB: rd_val = {24'h0, stop_tab_r};
         R_OIMG: rd_val = {24'h0, out_img_r};
         R_IIMG: rd_val = {24'h0, in_img_r};
         R_IMMI: rd_val = {24'h0, din_r};
         R_AIN: rd_val = {16'h0, ain_val};
         R_AOUT: rd_val = {16'h0, o_aout};
         R_SCTL: rd_val = {24'h0, save_ctl_r[`PLC_SAVE_REQ_BIT], 5'h00,
            save_ctl_r[1:0]};
         R_SADR: rd_val = {ee_zero, save_adr_r};
         default: rd_val = 32'h00000000;
      endcase
   end

   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_hrdata <= 32'h00000000;
         o_hreadyout <= 1'b1;
         o_hresp <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_sel_r <= R_NONE;
         save_ctl_r <= 8'h00;
         save_adr_r <= 16'h0000;
         stop_tab_r <= `PLC_STOP_TAB_RESET;
         pct_r <= `PLC_PCT_RESET;
         freeze_r <= 1'b0;
         filt_en_r <= 1'b0;
         ain_filt_r <= 16'h0000;
         o_aout <= 16'h0000;
      end else begin
         ain_filt_r <= filt_sum[16:1];
         wr_pend_r <= addr_ok && i_hwrite;
         wr_sel_r <= sel_now;
         if (addr_ok && !i_hwrite)
            o_hrdata <= rd_val;
         // Hardware clear loses to a software set in the same cycle
         if (save_clr)
            save_ctl_r[`PLC_SAVE_REQ_BIT] <= 1'b0;
         if (wr_pend_r) begin
            case (wr_sel_r)
               R_CFG: begin
                  freeze_r <= i_hwdata[`PLC_CFG_FREEZE_BIT];
                  filt_en_r <= i_hwdata[`PLC_CFG_FILT_BIT];
                  if (pct_ok)
                     pct_r <= pct_wr;
               end
               R_TAB: stop_tab_r <= i_hwdata[7:0];
               R_AOUT: o_aout <= i_hwdata[15:0];
               R_SCTL: save_ctl_r <= {i_hwdata[`PLC_SAVE_REQ_BIT], 5'h00,
                  i_hwdata[1:0]};
               R_SADR: save_adr_r <= i_hwdata[15:0];
               default: save_adr_r <= save_adr_r;
            endcase
         end
      end
   end

   // ****************************************
   // Operating mode
   // ****************************************
   reg started_r;
   wire to_stop = sw_r == `PLC_SW_STOP && sw_prev_r != `PLC_SW_STOP;
   wire to_run = sw_r == `PLC_SW_RUN && sw_prev_r != `PLC_SW_RUN;

   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         o_run <= 1'b0;
         o_download_ok <= 1'b1;
         started_r <= 1'b0;
      end else if (!started_r) begin
         if (sw_ok_r) begin
            started_r <= 1'b1;
            o_run <= sw_r == `PLC_SW_RUN;
            o_download_ok <= sw_r != `PLC_SW_RUN;
         end
      end else if (to_stop || i_stop_instr || rem_stop) begin
         o_run <= 1'b0;
         o_download_ok <= 1'b1;
      end else if (to_run || rem_run) begin
         // Terminal position makes no edge, so the mode stays
         o_run <= 1'b1;
         o_download_ok <= 1'b0;
      end
   end

   // ****************************************
   // Scan sequencer and EEPROM save
   // ****************************************
   reg [5:0] state_nxt;
   reg [20:0] cnt_r;
   wire [20:0] comm_len = {15'h0000, pct_r} * `PLC_COMM_UNIT_CYC;
   wire save_req = save_ctl_r[`PLC_SAVE_REQ_BIT];
   wire imm_wr = wr_pend_r && wr_sel_r == R_IMMO && o_run;
   wire ee_end = o_ee_req && (i_ee_done || cnt_r >= SAVE_LIMIT);

   always @* begin
      state_nxt = state_r;
      save_clr = 1'b0;
      case (state_r)
         S_STOP: if (o_run) state_nxt = S_IN;
         S_IN: state_nxt = o_run ? S_EXEC : S_STOP;
         S_EXEC: begin
            if (!o_run)
               state_nxt = S_STOP;
            else if (i_scan_done)
               state_nxt = S_OUT;
         end
         S_OUT: state_nxt = o_run ? S_SAVE : S_STOP;
         S_SAVE: begin
            if (!save_req) begin
               state_nxt = S_COMM;
            end else if (save_ctl_r[1:0] == `PLC_SIZE_NONE) begin
               save_clr = 1'b1;
               state_nxt = S_COMM;
            end else if (ee_end) begin
               save_clr = 1'b1;
               state_nxt = S_COMM;
            end
         end
         S_COMM: begin
            if (!o_run)
               state_nxt = S_STOP;
            else if (cnt_r >= comm_len)
               state_nxt = S_IN;
         end
         default: state_nxt = S_STOP;
      endcase
   end

   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         state_r <= S_STOP;
         cnt_r <= 21'h000000;
         in_img_r <= 8'h00;
         out_img_r <= 8'h00;
         o_dout <= 8'h00;
         o_exec <= 1'b0;
         o_comm_active <= 1'b0;
         o_ee_req <= 1'b0;
         o_ee_addr <= 16'h0000;
         o_ee_size <= 2'h0;
      end else begin
         state_r <= state_nxt;
         o_exec <= state_nxt == S_EXEC;
         o_comm_active <= state_nxt == S_COMM && comm_len != 21'h000000;
         if (state_nxt != state_r)
            cnt_r <= 21'h000000;
         else
            cnt_r <= cnt_r + 21'h000001;
         if (state_r == S_IN)
            in_img_r <= din_r;
         if (wr_pend_r && wr_sel_r == R_OIMG)
            out_img_r <= i_hwdata[7:0];
         if (state_r == S_OUT && o_run)
            o_dout <= out_img_r;
         if (state_nxt == S_STOP && state_r != S_STOP && !freeze_r)
            o_dout <= stop_tab_r;
         if (imm_wr) begin
            o_dout <= i_hwdata[7:0];
            out_img_r <= i_hwdata[7:0];
         end
         // Only the internal variable area is addressed; no cartridge path
         if (state_r == S_SAVE && save_req && !o_ee_req &&
            save_ctl_r[1:0] != `PLC_SIZE_NONE) begin
            o_ee_req <= 1'b1;
            o_ee_addr <= save_adr_r;
            o_ee_size <= save_ctl_r[1:0];
         end else if (ee_end) begin
            o_ee_req <= 1'b0;
         end
      end
   end

   // ****************************************
   // Interrupt queues, two priority groups
   // ****************************************
   reg [1:0] q_id_r [0:7];
   reg [1:0] qh_r [0:1];
   reg [2:0] qn_r [0:1];
   reg [7:0] pend_r, queued_r;
   wire [7:0] waiting = pend_r & ~queued_r;
   wire [2:0] fe0 = first_evt(waiting[3:0]);
   wire [2:0] fe1 = first_evt(waiting[7:4]);
   wire q0_full = qn_r[0] == `PLC_QDEPTH;
   wire q1_full = qn_r[1] == `PLC_QDEPTH;
   wire issue = o_run && !o_isr_valid && (qn_r[0] != 3'h0 || qn_r[1] != 3'h0);
   wire pop_g = qn_r[0] == 3'h0;
   wire [1:0] head_id = q_id_r[{pop_g, qh_r[pop_g]}];
   wire [2:0] pop_evt = {pop_g, head_id};
   wire push0 = fe0[2] && !q0_full;
   wire push1 = fe1[2] && !q1_full;
   wire pop0 = issue && !pop_g;
   wire pop1 = issue && pop_g;
   wire [1:0] tail0 = qh_r[0] + qn_r[0][1:0];
   wire [1:0] tail1 = qh_r[1] + qn_r[1][1:0];
   reg [7:0] pop_mask;
   integer i;

   always @* begin
      pop_mask = 8'h00;
      if (issue)
         pop_mask[pop_evt] = 1'b1;
   end

   always @(posedge i_clock) begin
      if (i_sys_rst) begin
         pend_r <= 8'h00;
         queued_r <= 8'h00;
         for (i = 0; i < 2; i = i + 1) begin
            qh_r[i] <= 2'h0;
            qn_r[i] <= 3'h0;
         end
         for (i = 0; i < 8; i = i + 1)
            q_id_r[i] <= 2'h0;
         o_isr_valid <= 1'b0;
         o_isr_id <= 3'h0;
      end else begin
         // A new arrival during its own service is kept and requeued
         pend_r <= (pend_r & ~pop_mask) | i_int_evt;
         queued_r <= (queued_r & ~pop_mask) |
            ({4'h0, push0, 3'h0} >> (3'h3 - fe0[1:0])) |
            ({push1, 7'h00} >> (3'h3 - fe1[1:0]));
         if (push0)
            q_id_r[{1'b0, tail0}] <= fe0[1:0];
         if (push1)
            q_id_r[{1'b1, tail1}] <= fe1[1:0];
         if (pop0)
            qh_r[0] <= qh_r[0] + 2'h1;
         if (pop1)
            qh_r[1] <= qh_r[1] + 2'h1;
         qn_r[0] <= qn_r[0] + {2'h0, push0} - {2'h0, pop0};
         qn_r[1] <= qn_r[1] + {2'h0, push1} - {2'h0, pop1};
         if (issue) begin
            o_isr_valid <= 1'b1;
            o_isr_id <= pop_evt;
         end else if (i_isr_done) begin
            o_isr_valid <= 1'b0;
         end
      end
   end

endmodule // plc_mode_save

`default_nettype wire

//--- plc_mode_save_assertions.sv
`timescale 1ns/1ns
`default_nettype none
`include "plc_defs.vh"
// ****************************************
// Port checks
// ****************************************
module plc_mode_save_checker #(
   parameter [63:0] SAVE_MAX_CYC = 64'h00000000001312d0
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [1:0] i_mode_sw,
   input wire logic i_stop_instr,
   input wire logic i_isr_done,
   input wire logic o_run,
   input wire logic o_download_ok,
   input wire logic o_exec,
   input wire logic o_comm_active,
   input wire logic o_ee_req,
   input wire logic [15:0] o_ee_addr,
   input wire logic [1:0] o_ee_size,
   input wire logic o_isr_valid
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   logic [63:0] ee_cnt_r;
   // Counter, since a save may last far beyond a repetition bound
   always @(posedge i_clock) begin
      if (i_sys_rst || !o_ee_req) begin
         ee_cnt_r <= 64'h0;
      end else begin
         ee_cnt_r <= ee_cnt_r + 64'h1;
      end
   end
   a_mode_download: assert property (o_download_ok == !o_run)
      else $error("download flag not inverse of run");
   a_switch_halts: assert property (
      (i_mode_sw == `PLC_SW_STOP) [*8] |=> !o_exec)
      else $error("execution goes on with switch at stop");
   a_powerup_stop: assert property (
      $fell(i_sys_rst) && i_mode_sw == `PLC_SW_STOP |-> !o_run [*8])
      else $error("run after power-up with switch at stop");
   a_stop_instr: assert property (
      o_exec && i_stop_instr |-> ##[1:3] !o_run)
      else $error("stop instruction ignored");
   a_ee_stable: assert property (
      o_ee_req && $past(o_ee_req) |-> $stable(o_ee_addr) && $stable(o_ee_size))
      else $error("save address or size moved during request");
   a_ee_size_set: assert property (
      o_ee_req |-> o_ee_size != `PLC_SIZE_NONE)
      else $error("save request with size zero");
   a_ee_bounded: assert property (ee_cnt_r < SAVE_MAX_CYC)
      else $error("save request held too long");
   a_isr_release: assert property (
      o_isr_valid && i_isr_done |=> !o_isr_valid)
      else $error("routine still valid after done");
   a_isr_in_run: assert property (
      $rose(o_isr_valid) |-> $past(o_run))
      else $error("routine issued outside run");
   a_exec_no_comm: assert property (!(o_exec && o_comm_active))
      else $error("execution overlaps comm slice");
endmodule // plc_mode_save_checker

bind plc_mode_save plc_mode_save_checker #(.SAVE_MAX_CYC(SAVE_MAX_CYC)) u_chk (
   .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_mode_sw(i_mode_sw),
   .i_stop_instr(i_stop_instr), .i_isr_done(i_isr_done), .o_run(o_run),
   .o_download_ok(o_download_ok), .o_exec(o_exec),
   .o_comm_active(o_comm_active), .o_ee_req(o_ee_req),
   .o_ee_addr(o_ee_addr), .o_ee_size(o_ee_size), .o_isr_valid(o_isr_valid)
);
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
`include "plc_defs.vh"
// ****************************************
// Bench top
// ****************************************
module tb;
   typedef struct {
      logic [11:0] wa;
      logic [31:0] wd;
      logic [11:0] ra;
      logic [31:0] ex;
   } plc_row_t;
   localparam [63:0] SMAX = 64'h40;
   localparam [11:0] A_CTL = {`PLC_IDX_SAVE_CTRL, 2'h0};
   localparam [11:0] A_SAD = {`PLC_IDX_SAVE_ADDR, 2'h0};
   logic clk, rst, hsel, hwrite, hreadyout, hresp, run, dl_ok, exec, comm;
   logic [31:0] haddr, hwdata, hrdata, rdata;
   logic [1:0] htrans, mode_sw, ee_size, sz;
   logic [2:0] hsize, isr_id;
   logic [7:0] din, int_evt, dout, save_cnt, cnt0;
   logic [15:0] ain, aout, ee_addr, last_addr;
   logic stop_i, isr_done, ee_req, isr_v, scan_done, ee_done, slow, seen;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int n, k, s;
   logic [2:0] ids [3] = '{3'h5, 3'h2, 3'h6};
   plc_row_t rows [11] = '{
      '{12'h040, 32'h0, `PLC_A_CFG, 32'h00000a00},
      '{12'h040, 32'h0, `PLC_A_STOP_TAB, 32'h0},
      '{12'h040, 32'hffffffff, 12'h040, 32'h0},
      '{`PLC_A_CFG, 32'h00000b00, `PLC_A_CFG, 32'h00000a00},
      '{`PLC_A_CFG, 32'h00003700, `PLC_A_CFG, 32'h00000a00},
      '{`PLC_A_CFG, 32'h00003200, `PLC_A_CFG, 32'h00003200},
      '{`PLC_A_CFG, 32'h00000500, `PLC_A_CFG, 32'h00000500},
      '{A_SAD, 32'h00001234, A_SAD, 32'h00001234},
      '{`PLC_A_IMM_OUT, 32'hff, `PLC_A_OUT_IMG, 32'h0},
      '{`PLC_A_MODE, 32'h1, `PLC_A_MODE, 32'h0},
      '{`PLC_A_STOP_TAB, 32'h5a, `PLC_A_STOP_TAB, 32'h5a}
   };

   plc_mode_save #(.SAVE_MAX_CYC(SMAX)) u_dut (
      .i_clock(clk), .i_sys_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
      .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
      .i_hwdata(hwdata), .i_hready(hreadyout), .o_hrdata(hrdata),
      .o_hreadyout(hreadyout), .o_hresp(hresp), .i_mode_sw(mode_sw),
      .i_din(din), .i_ain(ain), .i_scan_done(scan_done),
      .i_stop_instr(stop_i), .i_int_evt(int_evt), .i_isr_done(isr_done),
      .i_ee_done(ee_done), .o_run(run), .o_download_ok(dl_ok),
      .o_exec(exec), .o_comm_active(comm), .o_dout(dout), .o_aout(aout),
      .o_ee_req(ee_req), .o_ee_addr(ee_addr), .o_ee_size(ee_size),
      .o_isr_valid(isr_v), .o_isr_id(isr_id)
   );
   plc_far_model u_far (
      .i_clock(clk), .i_sys_rst(rst), .i_slow(slow), .i_exec(exec),
      .i_ee_req(ee_req), .i_ee_addr(ee_addr), .o_scan_done(scan_done),
      .o_ee_done(ee_done), .o_save_cnt(save_cnt), .o_last_addr(last_addr)
   );

   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // Entered right after a rising edge; read data lands in rdata
   task automatic bus(input logic [11:0] a, input logic w,
                      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= `PLC_HTRANS_NONSEQ;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rdata = hrdata;
   endtask

   task automatic wait_on(input int sel, input logic lvl);
      for (n = 0; n < 3000; n++) begin
         if ((sel == 0 ? run : sel == 1 ? exec : isr_v) === lvl) break;
         @(posedge clk);
      end
   endtask

   task stop_test;
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (ee_req === 1'b1) begin
         seen <= 1'b1;
         sz <= ee_size;
      end
      if (cyc == 60000) begin
         error_cnt++;
         stop_test;
      end
   end

   initial begin
      rst = 1'b1;
      {hsel, hwrite, stop_i, isr_done, slow, seen} = 6'h00;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'h0;
      hsize = `PLC_HSIZE_WORD;
      mode_sw = `PLC_SW_STOP;
      din = 8'ha5;
      ain = 16'h0777;
      int_evt = 8'h00;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (8) @(posedge clk);
      chk(run, 1'b0);
      for (k = 0; k < 11; k++) begin
         bus(rows[k].wa, 1'b1, rows[k].wd);
         bus(rows[k].ra, 1'b0, 32'h0);
         chk(rdata, rows[k].ex);
      end
      $display("register table done");
      mode_sw <= `PLC_SW_TERM;
      repeat (8) @(posedge clk);
      chk(run, 1'b0);
      bus(`PLC_A_MODE, 1'b1, 32'h1);
      wait_on(0, 1'b1);
      chk(dl_ok, 1'b0);
      bus(`PLC_A_MODE, 1'b0, 32'h0);
      chk(rdata, 32'h3);
      mode_sw <= `PLC_SW_STOP;
      wait_on(0, 1'b0);
      // Stop table reaches the pins one edge after the mode drops
      repeat (2) @(posedge clk);
      chk(dout, 8'h5a);
      mode_sw <= `PLC_SW_RUN;
      wait_on(0, 1'b1);
      chk(run, 1'b1);
      $display("mode switch done");
      wait_on(1, 1'b0);
      wait_on(1, 1'b1);
      din <= 8'h3c;
      repeat (6) @(posedge clk);
      bus(`PLC_A_IMM_IN, 1'b0, 32'h0);
      chk(rdata, 32'h3c);
      bus(`PLC_A_IN_IMG, 1'b0, 32'h0);
      chk(rdata, 32'ha5);
      wait_on(1, 1'b0);
      wait_on(1, 1'b1);
      bus(`PLC_A_OUT_IMG, 1'b1, 32'h96);
      chk(dout, 8'h00);
      wait_on(1, 1'b0);
      repeat (3) @(posedge clk);
      chk(dout, 8'h96);
      bus(`PLC_A_IMM_OUT, 1'b1, 32'h81);
      repeat (2) @(posedge clk);
      chk(dout, 8'h81);
      bus(`PLC_A_OUT_IMG, 1'b0, 32'h0);
      chk(rdata, 32'h81);
      bus(`PLC_A_AOUT, 1'b1, 32'h4321);
      @(posedge clk);
      chk(aout, 16'h4321);
      bus(`PLC_A_AIN, 1'b0, 32'h0);
      chk(rdata, 32'h0777);
      $display("io image done");
      bus(`PLC_A_CFG, 1'b1, 32'h0501);
      mode_sw <= `PLC_SW_TERM;
      wait_on(1, 1'b0);
      wait_on(1, 1'b1);
      stop_i <= 1'b1;
      @(posedge clk);
      stop_i <= 1'b0;
      wait_on(0, 1'b0);
      chk(dl_ok, 1'b1);
      chk(dout, 8'h81);
      bus(`PLC_A_MODE, 1'b1, 32'h1);
      wait_on(0, 1'b1);
      chk(run, 1'b1);
      $display("stop instruction done");
      for (s = 0; s < 5; s++) begin
         slow <= (s == 4);
         seen = 1'b0;
         cnt0 = save_cnt;
         bus(A_SAD, 1'b1, 32'h40 + s);
         // Last pass uses a real size so the unanswered save must time out
         bus(A_CTL, 1'b1, {24'h0, 1'b1, 5'h0,
            (s == 4) ? 2'h3 : s[1:0]});
         for (k = 0; k < 2000; k++) begin
            bus(A_CTL, 1'b0, 32'h0);
            if (rdata[7] === 1'b0) break;
         end
         chk(rdata[7], 1'b0);
         chk(seen, s != 0);
         chk(save_cnt, (s % 4) ? cnt0 + 8'h01 : cnt0);
         if (s % 4) chk({sz, last_addr}, {s[1:0], 16'h40 + s[15:0]});
         if (s == 4) chk(sz, 2'h3);
      end
      slow <= 1'b0;
      $display("eeprom save done");
      int_evt <= 8'h60;
      @(posedge clk);
      int_evt <= 8'h00;
      for (k = 0; k < 3; k++) begin
         wait_on(2, 1'b1);
         chk(isr_id, ids[k]);
         // High group event queued while the first routine still runs
         if (k == 0) begin
            int_evt <= 8'h04;
            @(posedge clk);
            int_evt <= 8'h00;
            repeat (3) @(posedge clk);
         end
         isr_done <= 1'b1;
         @(posedge clk);
         isr_done <= 1'b0;
         @(posedge clk);
      end
      $display("interrupt order done");
      stop_test;
   end
endmodule // tb
`default_nettype wire
